// file: rtl/dpr_pkg.sv
package dpr_pkg;
    // clock and time base
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYC      = CLK_MHZ * TICK_US;
    localparam int unsigned TICK_CNT_W    = 6;
    // delays, in their own units, and in ticks
    localparam int unsigned SETUP_STEP_MS = 500;
    localparam int unsigned SETUP_STEP_TK = SETUP_STEP_MS * 1000 / TICK_US;
    localparam int unsigned TEST_INI_MS   = 42;
    localparam int unsigned TEST_INI_TK   = TEST_INI_MS * 1000 / TICK_US;
    localparam int unsigned PULSE0_US     = 1280;
    localparam int unsigned PULSE1_MS     = 100;
    localparam int unsigned PULSE2_MS     = 210;
    localparam int unsigned PULSE3_MS     = 360;
    localparam int unsigned PULSE0_TK     = PULSE0_US / TICK_US;
    localparam int unsigned PULSE1_TK     = PULSE1_MS * 1000 / TICK_US;
    localparam int unsigned PULSE2_TK     = PULSE2_MS * 1000 / TICK_US;
    localparam int unsigned PULSE3_TK     = PULSE3_MS * 1000 / TICK_US;
    localparam int unsigned SHORT_SHIFT   = 7;
    localparam int unsigned COUNT_W       = 24;
    // setup delay selection in half-second steps
    localparam logic [4:0]  SETUP_SEL_MIN = 5'h01;
    localparam logic [4:0]  SETUP_SEL_MAX = 5'h14;
    // register map
    localparam int unsigned ADDR_W        = 12;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_COUNT    = 12'h008;
    // control fields
    localparam int unsigned CTRL_SEL_LSB  = 0;
    localparam int unsigned CTRL_SEL_MSB  = 4;
    localparam int unsigned CTRL_FIX_BIT  = 5;
    localparam int unsigned CTRL_PSEL_LSB = 6;
    localparam int unsigned CTRL_PSEL_MSB = 7;
    localparam int unsigned CTRL_W        = 8;
    localparam logic [7:0]  CTRL_RESET    = 8'h08;
    // status fields
    localparam int unsigned ST_TEST_BIT   = 0;
    localparam int unsigned ST_RST_BIT    = 1;
    localparam int unsigned ST_BTN_BIT    = 2;
    localparam int unsigned ST_UV_BIT     = 3;
    localparam int unsigned ST_WAIT_BIT   = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_HOLD,
        ST_PULSE,
        ST_WAIT_REL,
        ST_TEST_INI,
        ST_TEST_IND
    } seq_state_e;
endpackage

// file: rtl/delayed_pushbutton_reset.sv
`timescale 1ns/1ps
module delayed_pushbutton_reset
    import dpr_pkg::*;
#(
    parameter bit          ACTIVE_HIGH = 1'b0,
    parameter bit          OPEN_DRAIN  = 1'b1,
    parameter int unsigned P_STEP_TK   = SETUP_STEP_TK,
    parameter int unsigned P_INI_TK    = TEST_INI_TK,
    parameter int unsigned P_PULSE1_TK = PULSE1_TK,
    parameter int unsigned P_PULSE2_TK = PULSE2_TK,
    parameter int unsigned P_PULSE3_TK = PULSE3_TK
) (
    input  wire logic              I_CLK,
    input  wire logic              I_NRST,
    input  wire logic              I_BUTTON_IN_N,
    input  wire logic              I_TEST_ENTRY_LEVEL,
    input  wire logic              I_SUPPLY_OK,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    output logic                   O_RST_OUT,
    output logic                   O_RST_OE
);

    ////////////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        seq_state_e            st;
        logic [COUNT_W-1:0]    cnt;
        logic [TICK_CNT_W-1:0] div;
        logic                  tick;
        logic [CTRL_W-1:0]     ctrl;
        logic                  test_mode;
        logic                  uv_hold;
        logic                  rst_out;
        logic                  rst_oe;
        logic [31:0]           prdata;
    } state_s;

    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYC - 1);
    localparam logic                  OUT_IDLE  = OPEN_DRAIN ? 1'b0 : ~ACTIVE_HIGH;
    localparam logic                  OE_IDLE   = OPEN_DRAIN ? ACTIVE_HIGH : 1'b1;

    localparam state_s RESET_STATE = '{
        st:        ST_IDLE,
        cnt:       '0,
        div:       '0,
        tick:      1'b0,
        ctrl:      CTRL_RESET,
        test_mode: 1'b0,
        uv_hold:   1'b0,
        rst_out:   OUT_IDLE,
        rst_oe:    OE_IDLE,
        prdata:    32'h0000_0000
    };

    state_s s_q;
    state_s s_d;

    logic               btn_act;
    logic               asserted;
    logic               fixed_en;
    logic [4:0]         sel;
    logic [COUNT_W-1:0] setup_lim;
    logic [COUNT_W-1:0] press_lim;
    logic [COUNT_W-1:0] pulse_lim;
    logic [COUNT_W-1:0] cnt_inc;
    logic               wr_acc;
    logic               rd_setup;
    logic               addr_ok;
    logic               wr_bad;
    logic [4:0]         wr_sel;
    logic [31:0]        rd_val;

    ////////////////////////////////////////////////////////////////////////////////////////
    // delay limits
    assign btn_act  = ~I_BUTTON_IN_N;
    assign fixed_en = s_q.ctrl[CTRL_FIX_BIT];
    assign sel      = s_q.ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB];
    assign cnt_inc  = s_q.cnt + COUNT_W'(1);

    // sel never exceeds SETUP_SEL_MAX, so the product stays below 2**COUNT_W
    assign setup_lim = COUNT_W'(sel * P_STEP_TK);
    assign press_lim = s_q.test_mode ? (setup_lim >> SHORT_SHIFT)
                                     : setup_lim;

    always_comb begin
        case (s_q.ctrl[CTRL_PSEL_MSB:CTRL_PSEL_LSB])
            2'h0:    pulse_lim = COUNT_W'(PULSE0_TK);
            2'h1:    pulse_lim = COUNT_W'(P_PULSE1_TK);
            2'h2:    pulse_lim = COUNT_W'(P_PULSE2_TK);
            default: pulse_lim = COUNT_W'(P_PULSE3_TK);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, read data captured in the setup cycle
    assign wr_acc   = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    assign addr_ok  = (I_PADDR == ADDR_CTRL) | (I_PADDR == ADDR_STATUS)
                    | (I_PADDR == ADDR_COUNT);
    assign wr_sel   = I_PWDATA[CTRL_SEL_MSB:CTRL_SEL_LSB];
    // a setup selection outside 0.5 s .. 10 s is refused, keeping the old value
    assign wr_bad   = I_PWRITE & (I_PADDR == ADDR_CTRL)
                    & ((wr_sel < SETUP_SEL_MIN) | (wr_sel > SETUP_SEL_MAX));

    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & (~addr_ok | wr_bad
                     | (I_PWRITE & (I_PADDR != ADDR_CTRL)));

    // taken from the state: an open-drain active-high release looks like idle on the pins
    assign asserted = (s_q.st == ST_HOLD) | (s_q.st == ST_PULSE) | (s_q.st == ST_TEST_IND);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (I_PADDR == ADDR_CTRL) begin
            rd_val[CTRL_W-1:0] = s_q.ctrl;
        end else if (I_PADDR == ADDR_STATUS) begin
            rd_val[ST_TEST_BIT] = s_q.test_mode;
            rd_val[ST_RST_BIT]  = asserted;
            rd_val[ST_BTN_BIT]  = btn_act;
            rd_val[ST_UV_BIT]   = s_q.uv_hold;
            rd_val[ST_WAIT_BIT] = (s_q.st == ST_WAIT_REL);
        end else if (I_PADDR == ADDR_COUNT) begin
            rd_val[COUNT_W-1:0] = s_q.cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;

        // microsecond time base
        s_d.tick = 1'b0;
        if (s_q.div == TICK_LAST) begin
            s_d.div  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + TICK_CNT_W'(1);
        end

        if (rd_setup) begin
            s_d.prdata = rd_val;
        end
        if (wr_acc & ~O_PSLVERR) begin
            s_d.ctrl = I_PWDATA[CTRL_W-1:0];
        end

        // supply dropout seen while idle freezes the block with the pin released
        if (!I_SUPPLY_OK && s_q.st == ST_IDLE && !btn_act) begin
            s_d.uv_hold = 1'b1;
        end else if (I_SUPPLY_OK) begin
            s_d.uv_hold = 1'b0;
        end

        case (s_q.st)
            ST_IDLE: begin
                s_d.cnt = '0;
                if (s_q.uv_hold) begin
                    s_d.st = ST_IDLE;
                end else if (I_TEST_ENTRY_LEVEL && !s_q.test_mode) begin
                    s_d.st = ST_TEST_INI;
                end else if (btn_act) begin
                    s_d.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (!btn_act) begin
                    // short closure: count discarded, output untouched
                    s_d.st  = ST_IDLE;
                    s_d.cnt = '0;
                end else if (s_q.tick) begin
                    if (cnt_inc >= press_lim) begin
                        s_d.cnt = '0;
                        s_d.st  = fixed_en ? ST_PULSE : ST_HOLD;
                    end else begin
                        s_d.cnt = cnt_inc;
                    end
                end
            end
            ST_HOLD: begin
                if (!btn_act) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_PULSE: begin
                // button state deliberately not looked at while the pulse runs
                if (s_q.tick) begin
                    if (cnt_inc >= pulse_lim) begin
                        s_d.cnt = '0;
                        s_d.st  = btn_act ? ST_WAIT_REL : ST_IDLE;
                    end else begin
                        s_d.cnt = cnt_inc;
                    end
                end
            end
            ST_WAIT_REL: begin
                if (!btn_act) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_TEST_INI: begin
                if (!I_TEST_ENTRY_LEVEL) begin
                    // level gone before the delay ran out: no lock
                    s_d.st  = ST_IDLE;
                    s_d.cnt = '0;
                end else if (s_q.tick) begin
                    if (cnt_inc >= COUNT_W'(P_INI_TK)) begin
                        s_d.cnt       = '0;
                        s_d.test_mode = 1'b1;
                        s_d.st        = fixed_en ? ST_PULSE : ST_TEST_IND;
                    end else begin
                        s_d.cnt = cnt_inc;
                    end
                end
            end
            ST_TEST_IND: begin
                if (!I_TEST_ENTRY_LEVEL) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st  = ST_IDLE;
                s_d.cnt = '0;
            end
        endcase

        // pin drive follows the next state so the output is a flop
        if (s_d.st == ST_HOLD || s_d.st == ST_PULSE || s_d.st == ST_TEST_IND) begin
            s_d.rst_out = OPEN_DRAIN ? 1'b0 : ACTIVE_HIGH;
            s_d.rst_oe  = OPEN_DRAIN ? ~ACTIVE_HIGH : 1'b1;
        end else begin
            s_d.rst_out = OUT_IDLE;
            s_d.rst_oe  = OE_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // reset models the power-on restart, the only way out of test mode
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_PRDATA  = s_q.prdata;
    assign O_RST_OUT = s_q.rst_out;
    assign O_RST_OE  = s_q.rst_oe;

endmodule

// file: dv/dpr_checker.sv
`timescale 1ns/1ps
module dpr_checker
    import dpr_pkg::*;
(
    input wire logic              I_CLK,
    input wire logic              I_NRST,
    input wire logic              I_BUTTON_IN_N,
    input wire logic              I_TEST_ENTRY_LEVEL,
    input wire logic              I_SUPPLY_OK,
    input wire logic              I_PSEL,
    input wire logic              I_PENABLE,
    input wire logic              I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0]       I_PWDATA,
    input wire logic [31:0]       O_PRDATA,
    input wire logic              O_PREADY,
    input wire logic              O_PSLVERR,
    input wire logic              O_RST_OUT,
    input wire logic              O_RST_OE
);
    logic fix_q;
    logic idle_lo;
    logic idle_lo_q;
    logic uv_q;
    assign idle_lo = !I_SUPPLY_OK && !O_RST_OE && I_BUTTON_IN_N && !I_TEST_ENTRY_LEVEL;
    // mirror of the fixed-pulse option; only accepted control writes move it
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            fix_q <= CTRL_RESET[CTRL_FIX_BIT];
        end else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == ADDR_CTRL
                     && I_PWDATA[4:0] != 5'h0 && I_PWDATA[4:0] <= SETUP_SEL_MAX) begin
            fix_q <= I_PWDATA[CTRL_FIX_BIT];
        end
    end
    // two idle samples under low supply: by then the block is idle and must freeze
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            idle_lo_q <= 1'h0;
            uv_q      <= 1'h0;
        end else begin
            idle_lo_q <= idle_lo;
            if (I_SUPPLY_OK) begin
                uv_q <= 1'h0;
            end else if (idle_lo_q && idle_lo) begin
                uv_q <= 1'h1;
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    a_press_first: assert property ($rose(O_RST_OE) && !$past(I_TEST_ENTRY_LEVEL)
        |-> !$past(I_BUTTON_IN_N) && !$past(I_BUTTON_IN_N, 8)) else $error("early reset");
    // indication end is excluded for one cycle; its lag is one cycle, as for a release
    a_release_drops: assert property (O_RST_OE && !fix_q && I_BUTTON_IN_N
        && !I_TEST_ENTRY_LEVEL && !$past(I_TEST_ENTRY_LEVEL) |=> !O_RST_OE)
        else $error("reset outlived press");
    a_hold_pressed: assert property (O_RST_OE && !fix_q && !I_BUTTON_IN_N
        |=> O_RST_OE) else $error("reset dropped while held");
    a_pulse_fixed: assert property ($rose(O_RST_OE) && fix_q |-> O_RST_OE [*8])
        else $error("fixed pulse cut short");
    a_od_drive: assert property (!O_RST_OUT) else $error("open drain drove high");
    a_supply_idle: assert property (uv_q |-> !O_RST_OE)
        else $error("reset during dropout");
    a_reset_clears: assert property (disable iff (1'h0) !I_NRST
        |=> !O_RST_OE && O_PRDATA == 32'h0) else $error("reset state wrong");
    a_err_unmapped: assert property (I_PSEL && I_PENABLE && I_PADDR > ADDR_COUNT
        |-> O_PSLVERR) else $error("unmapped access accepted");
    a_err_ro_write: assert property (I_PSEL && I_PENABLE && I_PWRITE
        && (I_PADDR == ADDR_STATUS || I_PADDR == ADDR_COUNT) |-> O_PSLVERR)
        else $error("read-only write accepted");
    cover property ($rose(O_RST_OE) && fix_q);
    cover property ($rose(O_RST_OE) && !fix_q);
    cover property (O_PSLVERR);
    cover property (uv_q && !I_BUTTON_IN_N);
endmodule

bind delayed_pushbutton_reset dpr_checker dpr_checker_inst (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_BUTTON_IN_N(I_BUTTON_IN_N),
    .I_TEST_ENTRY_LEVEL(I_TEST_ENTRY_LEVEL), .I_SUPPLY_OK(I_SUPPLY_OK), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_RST_OUT(O_RST_OUT), .O_RST_OE(O_RST_OE)
);

// file: dv/dpr_button_host.sv
`timescale 1ns/1ps
module dpr_button_host #(
    parameter bit ACTIVE_HIGH = 1'h0
) (
    input  wire logic i_press,
    input  wire logic i_rst_out,
    input  wire logic i_rst_oe,
    output logic      o_button_in_n,
    output logic      o_host_reset
);
    logic pin;
    // closed contact grounds the line, the input pull-up holds it high otherwise
    assign o_button_in_n = !i_press;
    // an undriven pin floats to the board pull-up, never to the last driven level
    assign pin = i_rst_oe ? i_rst_out : 1'h1;
    assign o_host_reset = (pin == ACTIVE_HIGH);
endmodule

// file: dv/delayed_pushbutton_reset_test.sv
`timescale 1ns/1ps
module delayed_pushbutton_reset_test;
    import dpr_pkg::*;
    localparam int unsigned STEP = 128;
    logic        clk, nrst, press, tlvl, sup, psel, pen, pwr, pready, perr;
    logic        rst_out, rst_oe, btn_n, host_rst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          error_cnt, comparisons, cyc, n;

    delayed_pushbutton_reset #(
        .P_STEP_TK(STEP), .P_INI_TK(40), .P_PULSE1_TK(20), .P_PULSE2_TK(30), .P_PULSE3_TK(40)
    ) delayed_pushbutton_reset_inst (
        .I_CLK(clk), .I_NRST(nrst), .I_BUTTON_IN_N(btn_n), .I_TEST_ENTRY_LEVEL(tlvl),
        .I_SUPPLY_OK(sup), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
        .O_RST_OUT(rst_out), .O_RST_OE(rst_oe)
    );
    dpr_button_host #(.ACTIVE_HIGH(1'h0)) dpr_button_host_inst (
        .i_press(press), .i_rst_out(rst_out), .i_rst_oe(rst_oe),
        .o_button_in_n(btn_n), .o_host_reset(host_rst)
    );
    ////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] lo, hi, got);
        comparisons++;
        if ($isunknown(got) || got < lo || got > hi) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // d is the write data, or the expected read data
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        @(posedge clk);
        psel   <= 1'h1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        chk("pslverr", {31'h0, e}, {31'h0, e}, {31'h0, perr});
        if (!w) chk("prdata", d, d, prdata);
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask
    task automatic push(input logic v);
        @(posedge clk);
        press <= v;
    endtask
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
    endtask
    task automatic wait_lvl(input logic v, input int lim);
        n = 0;
        while (host_rst !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic quiet(input string what, input int c, input logic v);
        int bad = 0;
        repeat (c) begin
            @(negedge clk);
            if (host_rst !== v) bad++;
        end
        chk(what, 32'h0, 32'h0, bad);
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        apb(1'h0, ADDR_CTRL, {24'h0, CTRL_RESET}, 1'h0);
        apb(1'h0, ADDR_STATUS, 32'h0, 1'h0);
        apb(1'h0, 12'h00C, 32'h0, 1'h1);
        apb(1'h1, ADDR_COUNT, 32'h1, 1'h1);
        apb(1'h1, ADDR_CTRL, 32'h0, 1'h1);
        apb(1'h1, ADDR_CTRL, 32'h15, 1'h1);
        apb(1'h1, ADDR_CTRL, 32'h14, 1'h0);
        apb(1'h0, ADDR_CTRL, 32'h14, 1'h0);
    endtask
    task automatic t_press();
        apb(1'h1, ADDR_CTRL, 32'h1, 1'h0);
        push(1'h1);
        quiet("short press", 6000, 1'h0);
        push(1'h0);
        push(1'h1);
        wait_lvl(1'h1, 8000);
        chk("setup cycles", 6340, 6470, n);
        quiet("held", 100, 1'h1);
        apb(1'h0, ADDR_STATUS, 32'h6, 1'h0);
        push(1'h0);
        wait_lvl(1'h0, 5);
        chk("release lag", 2, 2, n);
    endtask
    task automatic t_fixed();
        for (int p = 1; p < 4; p++) begin
            apb(1'h1, ADDR_CTRL, 32'h21 | (p << CTRL_PSEL_LSB), 1'h0);
            push(1'h1);
            wait_lvl(1'h1, 8000);
            push(1'h0);
            wait_lvl(1'h0, 3000);
            chk("pulse cycles", 500 * (p + 1) - 52, 500 * (p + 1) + 52, n);
        end
        push(1'h1);
        wait_lvl(1'h1, 8000);
        wait_lvl(1'h0, 3000);
        quiet("no rearm", 7000, 1'h0);
        apb(1'h0, ADDR_STATUS, 32'h14, 1'h0);
        push(1'h0);
    endtask
    task automatic t_supply();
        apb(1'h1, ADDR_CTRL, 32'h1, 1'h0);
        @(posedge clk);
        sup <= 1'h0;
        @(posedge clk);
        push(1'h1);
        quiet("supply low", 7000, 1'h0);
        apb(1'h0, ADDR_STATUS, 32'hC, 1'h0);
        push(1'h0);
        @(posedge clk);
        sup <= 1'h1;
    endtask
    task automatic t_test();
        apb(1'h1, ADDR_CTRL, 32'h2, 1'h0);
        @(posedge clk);
        tlvl <= 1'h1;
        wait_lvl(1'h1, 3000);
        chk("initial test cycles", 1950, 2060, n);
        quiet("indication", 200, 1'h1);
        @(posedge clk);
        tlvl <= 1'h0;
        wait_lvl(1'h0, 5);
        chk("indication end", 1, 3, n);
        apb(1'h0, ADDR_STATUS, 32'h1, 1'h0);
        push(1'h1);
        wait_lvl(1'h1, 400);
        chk("short setup cycles", 50, 160, n);
        push(1'h0);
        do_reset();
        apb(1'h0, ADDR_STATUS, 32'h0, 1'h0);
        push(1'h1);
        quiet("normal after restart", 600, 1'h0);
        push(1'h0);
        apb(1'h1, ADDR_CTRL, 32'h61, 1'h0);
        @(posedge clk);
        tlvl <= 1'h1;
        wait_lvl(1'h1, 3000);
        chk("fixed test entry cycles", 1950, 2060, n);
        wait_lvl(1'h0, 1500);
        chk("entry pulse cycles", 950, 1050, n);
        quiet("no re-entry", 2200, 1'h0);
        apb(1'h0, ADDR_STATUS, 32'h1, 1'h0);
        @(posedge clk);
        tlvl <= 1'h0;
    endtask
    initial begin
        {nrst, press, tlvl, psel, pen, pwr} = '0;
        sup    = 1'h1;
        paddr  = '0;
        pwdata = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        t_regs();
        t_press();
        t_fixed();
        t_supply();
        t_test();
        conclude();
    end
endmodule
